/* File: dcc_analog_model.sv */
// Behavioural model of the two analog comparator cores.
// Assumes the bench sets which input is higher on each core.
`timescale 1ns/10ps
`default_nettype none

module dcc_analog_model (
	input  wire logic [1:0] power_on,
	input  wire logic [1:0] plus_above,
	output var  logic [1:0] cmp_raw
);
	// ------------------------------------------------------------
	// Cores
	// ------------------------------------------------------------
	// An unpowered core gives a low result; change lands off the edge
	assign #1 cmp_raw = power_on & plus_above;
endmodule

`default_nettype wire

/* File: dcc_apb.sv */
// APB handshake for the comparator register file.
// Assumes an APB master on pclk; gives one wait state per access.
`timescale 1ns/10ps
`default_nettype none

module dcc_apb (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic psel,
	input  wire logic penable,
	output var  logic pready,
	output var  logic take,
	output var  logic commit
);

	typedef struct packed {
		logic ready;
	} dcc_apb_state_t;

	dcc_apb_state_t s_r;
	dcc_apb_state_t s_nxt;

	always_comb begin
		s_nxt       = s_r;
		// First access cycle prepares data, second one completes
		take        = psel && penable && !s_r.ready;
		commit      = psel && penable && s_r.ready;
		s_nxt.ready = take;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pready = s_r.ready;

endmodule
`default_nettype wire

/* File: dcc_pkg.sv */
// Constants shared by the dual comparator control block.
// Assumes a 32-bit APB bus with byte addresses and a 250 MHz pclk.
package dcc_pkg;

	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int NUM_CMP = 2;
	localparam int ADDR_W  = 12;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [11:0] ADDR_CTRL0    = 12'h000;
	localparam logic [11:0] ADDR_CTRL1    = 12'h004;
	localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
	localparam logic [11:0] ADDR_IRQ_MASK = 12'h00c;

	// ------------------------------------------------------------
	// Control register field positions
	// ------------------------------------------------------------
	localparam int BIT_SEL = 7;
	localparam int BIT_EN  = 6;
	localparam int BIT_INV = 5;
	localparam int BIT_RES = 4;
	localparam int BIT_RI  = 3;
	localparam int BIT_HY  = 0;

	// ------------------------------------------------------------
	// Values after reset
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_RST = 8'h81;
	localparam logic [1:0] MASK_RST = 2'h0;
	localparam logic [1:0] SYNC_STAGES_RST = 2'h0;

endpackage

/* File: dcc_sync.sv */
// Two-flop synchroniser for the asynchronous comparator results.
// Assumes the inputs come straight from the analog cores.
`timescale 1ns/10ps
`default_nettype none

module dcc_sync (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [1:0] async_in,
	output var  logic [1:0] sync_out
);

	typedef struct packed {
		logic [1:0] meta;
		logic [1:0] stage;
	} dcc_sync_state_t;

	dcc_sync_state_t s_r;
	dcc_sync_state_t s_nxt;

	always_comb begin
		s_nxt       = s_r;
		s_nxt.meta  = async_in;
		s_nxt.stage = s_r.meta;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sync_out = s_r.stage;

endmodule
`default_nettype wire

/* File: dcc_top.sv */
// Control and status logic for two analog comparators, APB slave.
// Assumes comparator results arrive asynchronously from analog cores.
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none

module dcc_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic [1:0]  cmp_raw,
	output var  logic [1:0]  cmp_power_on,
	output var  logic [1:0]  cmp_hysteresis_on,
	output var  logic [1:0]  cmp_pin_select,
	output var  logic [1:0]  cmp_pullup_off,
	output var  logic [1:0]  cmp_output_pin,
	output var  logic [1:0]  cmp_output_pin_oe,
	output var  logic        irq,
	output var  logic        wake
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0]  sel;
		logic [1:0]  en;
		logic [1:0]  inv;
		logic [1:0]  res;
		logic [1:0]  ri;
		logic [1:0]  hy;
		logic [1:0]  flag;
		logic [1:0]  mask;
		logic [31:0] rdata;
		logic        slverr;
		logic [1:0]  pin;
		logic [1:0]  pin_oe;
		logic [1:0]  pull_off;
		logic        irq;
		logic        wake;
	} dcc_state_t;

	dcc_state_t s_r;
	dcc_state_t s_nxt;

	logic [1:0] cmp_sync;
	logic       take;
	logic       commit;
	logic       wr_ok;
	logic [1:0] res_now;
	logic [1:0] clr;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [11:0] ctrl_addr(input int i);
		ctrl_addr = (i == 0) ? dcc_pkg::ADDR_CTRL0 : dcc_pkg::ADDR_CTRL1;
	endfunction

	function automatic logic [7:0] ctrl_byte(
		input dcc_state_t s,
		input int         i
	);
		logic [7:0] b;
		b                   = 8'h00;
		b[dcc_pkg::BIT_SEL] = s.sel[i];
		b[dcc_pkg::BIT_EN]  = s.en[i];
		b[dcc_pkg::BIT_INV] = s.inv[i];
		b[dcc_pkg::BIT_RES] = s.res[i];
		b[dcc_pkg::BIT_RI]  = s.ri[i];
		b[dcc_pkg::BIT_HY]  = s.hy[i];
		ctrl_byte           = b;
	endfunction

	// ------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------
	dcc_sync u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (cmp_raw),
		.sync_out (cmp_sync)
	);

	dcc_apb u_apb (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pready  (pready),
		.take    (take),
		.commit  (commit)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_nxt   = s_r;
		wr_ok   = commit && pwrite && pstrb[0];
		clr     = 2'h0;
		res_now = cmp_sync ^ s_r.inv;

		// Control writes; status and unused bits never stored
		for (int i = 0; i < dcc_pkg::NUM_CMP; i++) begin
			if (wr_ok && paddr == ctrl_addr(i)) begin
				s_nxt.sel[i] = pwdata[dcc_pkg::BIT_SEL];
				s_nxt.en[i]  = pwdata[dcc_pkg::BIT_EN];
				s_nxt.inv[i] = pwdata[dcc_pkg::BIT_INV];
				s_nxt.ri[i]  = pwdata[dcc_pkg::BIT_RI];
				s_nxt.hy[i]  = pwdata[dcc_pkg::BIT_HY];
			end
		end
		if (wr_ok && paddr == dcc_pkg::ADDR_IRQ_STAT) begin
			clr = pwdata[1:0];
		end
		if (wr_ok && paddr == dcc_pkg::ADDR_IRQ_MASK) begin
			s_nxt.mask = pwdata[1:0];
		end

		// Status bit is the synchronised result xor inv
		s_nxt.res  = res_now;
		// Change sets the flag; a set beats a same-cycle clear
		s_nxt.flag = (s_r.flag & ~clr) | (res_now ^ s_r.res);

		// Read data is prepared in the first access cycle
		if (take) begin
			s_nxt.rdata  = 32'h0000_0000;
			s_nxt.slverr = 1'b0;
			if (!pwrite) begin
				unique case (paddr)
					dcc_pkg::ADDR_CTRL0:
						s_nxt.rdata[7:0] = ctrl_byte(s_r, 0);
					dcc_pkg::ADDR_CTRL1:
						s_nxt.rdata[7:0] = ctrl_byte(s_r, 1);
					dcc_pkg::ADDR_IRQ_STAT:
						s_nxt.rdata[1:0] = s_r.flag;
					dcc_pkg::ADDR_IRQ_MASK:
						s_nxt.rdata[1:0] = s_r.mask;
					default:
						s_nxt.slverr = 1'b1;
				endcase
			end else begin
				unique case (paddr)
					dcc_pkg::ADDR_CTRL0,
					dcc_pkg::ADDR_CTRL1,
					dcc_pkg::ADDR_IRQ_STAT,
					dcc_pkg::ADDR_IRQ_MASK:
						s_nxt.slverr = 1'b0;
					default:
						s_nxt.slverr = 1'b1;
				endcase
			end
		end

		// Pad controls, interrupt and wake
		s_nxt.pin      = s_nxt.res;
		s_nxt.pin_oe   = s_nxt.sel & ~s_nxt.ri;
		s_nxt.pull_off = s_nxt.sel | s_nxt.en;
		s_nxt.irq      = |(s_nxt.flag & s_nxt.mask);
		s_nxt.wake     = |(s_nxt.flag & s_nxt.en);
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r          <= '0;
			s_r.sel      <= {2{dcc_pkg::CTRL_RST[dcc_pkg::BIT_SEL]}};
			s_r.en       <= {2{dcc_pkg::CTRL_RST[dcc_pkg::BIT_EN]}};
			s_r.inv      <= {2{dcc_pkg::CTRL_RST[dcc_pkg::BIT_INV]}};
			s_r.ri       <= {2{dcc_pkg::CTRL_RST[dcc_pkg::BIT_RI]}};
			s_r.hy       <= {2{dcc_pkg::CTRL_RST[dcc_pkg::BIT_HY]}};
			s_r.mask     <= dcc_pkg::MASK_RST;
			s_r.pin_oe   <= {2{dcc_pkg::CTRL_RST[dcc_pkg::BIT_SEL]}};
			s_r.pull_off <= {2{dcc_pkg::CTRL_RST[dcc_pkg::BIT_SEL]}};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign prdata            = s_r.rdata;
	assign pslverr           = s_r.slverr;
	assign cmp_power_on      = s_r.en;
	assign cmp_hysteresis_on = s_r.hy;
	assign cmp_pin_select    = s_r.sel;
	assign cmp_pullup_off    = s_r.pull_off;
	assign cmp_output_pin    = s_r.pin;
	assign cmp_output_pin_oe = s_r.pin_oe;
	assign irq               = s_r.irq;
	assign wake              = s_r.wake;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_wr_ctrl0;
		commit && pwrite && pstrb[0] && paddr == dcc_pkg::ADDR_CTRL0;
	endsequence

	sequence s_wr_ctrl1;
		commit && pwrite && pstrb[0] && paddr == dcc_pkg::ADDR_CTRL1;
	endsequence

	sequence s_rd_ctrl0;
		pready && psel && penable && !pwrite &&
			paddr == dcc_pkg::ADDR_CTRL0;
	endsequence

	property p_indep;
		s_wr_ctrl0 |=> $stable({s_r.sel[1], s_r.en[1], s_r.inv[1],
			s_r.ri[1], s_r.hy[1]});
	endproperty
	a_indep: assert property (p_indep)
		else $error("ctrl0 write disturbed channel 1");

	property p_status_read;
		s_rd_ctrl0 |-> prdata[4] == $past(s_r.res[0]);
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("status bit read mismatch");

	property p_pull_off;
		s_wr_ctrl0 ##0 pwdata[6] |=> cmp_pullup_off[0] ##1 cmp_pullup_off[0];
	endproperty
	a_pull_off: assert property (p_pull_off)
		else $error("pull-high not disconnected when enabled");

	property p_pin_sel;
		s_wr_ctrl1 ##0 pwdata[7] |=> cmp_pin_select[1] && cmp_pullup_off[1];
	endproperty
	a_pin_sel: assert property (p_pin_sel)
		else $error("pin select did not take effect");

	property p_power;
		s_wr_ctrl0 |=> cmp_power_on[0] == $past(pwdata[6]);
	endproperty
	a_power: assert property (p_power)
		else $error("power control did not follow write");

	property p_polarity;
		($stable(cmp_raw[0]) && $stable(s_r.inv[0]))[*4] |->
			s_r.res[0] == (cmp_raw[0] ^ s_r.inv[0]);
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("status bit not result xor polarity");

	property p_route;
		cmp_output_pin_oe[1] |-> s_r.sel[1] && !s_r.ri[1] &&
			cmp_output_pin[1] == s_r.res[1];
	endproperty
	a_route: assert property (p_route)
		else $error("output pin driven while routed internally");

	property p_unused;
		s_rd_ctrl0 |-> prdata[2:1] == 2'h0 && prdata[31:8] == 24'h0;
	endproperty
	a_unused: assert property (p_unused)
		else $error("unimplemented bits read nonzero");

	property p_hyst;
		s_wr_ctrl1 |=> cmp_hysteresis_on[1] == $past(pwdata[0]);
	endproperty
	a_hyst: assert property (p_hyst)
		else $error("hysteresis control did not follow write");

	property p_flag;
		s_r.res[1] != $past(s_r.res[1]) |-> s_r.flag[1];
	endproperty
	a_flag: assert property (p_flag)
		else $error("status change did not set flag");

	property p_wake;
		s_r.flag[0] && s_r.en[0] |-> wake;
	endproperty
	a_wake: assert property (p_wake)
		else $error("enabled flag did not raise wake");

	property p_irq;
		irq |-> |(s_r.flag & s_r.mask) ##1 1'b1;
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt without unmasked flag");

endmodule
`default_nettype wire

/* File: dual_comparator_control_tb.sv */
// Self-checking bench for the dual comparator control block.
// Assumes dcc_pkg and the analog core model are compiled first.
`timescale 1ns/10ps
`default_nettype none

module dual_comparator_control_tb;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb;
	logic        pready, pslverr, irq, wake, er;
	logic [1:0]  raw, pwr, hys, sel, puo, opin, ooe, above;
	int          fails, check_count, cyc;

	dcc_top i_dcc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cmp_raw(raw),
		.cmp_power_on(pwr), .cmp_hysteresis_on(hys),
		.cmp_pin_select(sel), .cmp_pullup_off(puo),
		.cmp_output_pin(opin), .cmp_output_pin_oe(ooe),
		.irq(irq), .wake(wake));
	dcc_analog_model i_dcc_analog_model (.power_on(pwr),
		.plus_above(above), .cmp_raw(raw));

	// ------------------------------------------------------------
	// Clock, timeout and helpers
	// ------------------------------------------------------------
	always #2 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
		logic [3:0] s);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		// Sampled at the rising edge; only the bench timeout ends a wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wt(int n);
		repeat (n) @(posedge pclk);
		@(negedge pclk);
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
		pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0; pstrb = 4'hf;
		above = 2'h0; fails = 0; check_count = 0; cyc = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		wt(1);
		chk("outs", {pwr, hys, sel, puo, ooe}, 32'h0ff);
		apb(1'b0, dcc_pkg::ADDR_CTRL0, 32'h0, 4'hf);
		chk("ctrl0", rd, 32'h81);
		apb(1'b0, dcc_pkg::ADDR_CTRL1, 32'h0, 4'hf);
		chk("ctrl1", rd, 32'h81);
		apb(1'b1, dcc_pkg::ADDR_CTRL0, 32'hff, 4'hf);
		wt(6);
		chk("oe0", {30'h0, ooe}, 32'h2);
		chk("pu", {30'h0, puo}, 32'h3);
		chk("wake", {31'h0, wake}, 32'h1);
		chk("irq", {31'h0, irq}, 32'h0);
		apb(1'b0, dcc_pkg::ADDR_CTRL0, 32'h0, 4'hf);
		chk("ctrl0 inv", rd, 32'hf9);
		apb(1'b0, dcc_pkg::ADDR_IRQ_STAT, 32'h0, 4'hf);
		chk("flags", rd, 32'h1);
		apb(1'b1, dcc_pkg::ADDR_IRQ_MASK, 32'h3, 4'hf);
		wt(1);
		chk("irq on", {31'h0, irq}, 32'h1);
		apb(1'b1, dcc_pkg::ADDR_IRQ_STAT, 32'h1, 4'hf);
		wt(1);
		chk("clr", {30'h0, irq, wake}, 32'h0);
		apb(1'b1, dcc_pkg::ADDR_CTRL1, 32'h40, 4'hf);
		wt(6);
		chk("outs1", {pwr, hys, sel, puo, ooe}, 32'h35c);
		above <= 2'h2;
		wt(6);
		apb(1'b0, dcc_pkg::ADDR_CTRL1, 32'h0, 4'hf);
		chk("ctrl1 res", rd, 32'h50);
		chk("opin", {30'h0, opin}, 32'h3);
		apb(1'b0, dcc_pkg::ADDR_IRQ_STAT, 32'h0, 4'hf);
		chk("flag1", rd, 32'h2);
		apb(1'b1, dcc_pkg::ADDR_IRQ_STAT, 32'h2, 4'hf);
		apb(1'b1, dcc_pkg::ADDR_CTRL1, 32'h0, 4'h0);
		apb(1'b0, dcc_pkg::ADDR_CTRL1, 32'h0, 4'hf);
		chk("strb", rd, 32'h50);
		apb(1'b0, 12'h010, 32'h0, 4'hf);
		chk("unmap", {er, rd[30:0]}, 32'h80000000);
		apb(1'b1, dcc_pkg::ADDR_CTRL1, 32'h86, 4'hf);
		wt(6);
		apb(1'b0, dcc_pkg::ADDR_CTRL1, 32'h0, 4'hf);
		chk("ctrl1 off", rd, 32'h80);
		chk("pins1", {ooe, opin, puo}, 32'h27);
		chk("irq wake", {30'h0, irq, wake}, 32'h2);
		end_sim();
	end
endmodule

`default_nettype wire
